// >>> common/video_regs_pkg.sv
// Shared constants and types for the power and input mode register bank.
// Assumes a single 10 MHz device clock and a byte-level host port engine.
package video_regs_pkg;

   localparam logic [7:0] POWER_CONTROL_ADDR     = 8'h00;
   localparam logic [7:0] INPUT_MODE_SELECT_ADDR = 8'h01;
   localparam logic [7:0] LAST_ADDR              = 8'h01;

   localparam logic [7:0] POWER_CONTROL_RESET     = 8'h12;
   localparam logic [7:0] INPUT_MODE_SELECT_RESET = 8'h00;
   // Reserved bits 0 and 3 always store zero
   localparam logic [7:0] MODE_WRITE_MASK         = 8'hF6;
   localparam logic [7:0] POWER_WRITE_MASK        = 8'hFF;

   localparam logic [1:0] ALIGN_CHROMA_RISE = 2'h0;
   localparam logic [1:0] ALIGN_LUMA_RISE   = 2'h3;

   localparam logic [2:0] MODE_SD_ONLY   = 3'h0;
   localparam logic [2:0] MODE_HD_SDR    = 3'h1;
   localparam logic [2:0] MODE_HD_DDR    = 3'h2;
   localparam logic [2:0] MODE_SD_HD_SDR = 3'h3;
   localparam logic [2:0] MODE_SD_HD_DDR = 3'h4;

   typedef struct packed {
      logic dac4_on;
      logic dac5_on;
      logic dac6_on;
      logic dac1_on;
      logic dac2_on;
      logic dac3_on;
      logic pll_off;
      logic sleep;
   } power_control_t;

   typedef struct packed {
      logic       bus_swap;
      logic [2:0] input_mode;
      logic       reserved3;
      logic [1:0] edge_align;
      logic       reserved0;
   } mode_select_t;

   typedef struct packed {
      logic       start;
      logic       stop;
      logic       wr_valid;
      logic [7:0] wr_data;
      logic       rd_req;
   } host_req_t;

   typedef struct packed {
      logic       ack_valid;
      logic       ack;
      logic       rd_valid;
      logic [7:0] rd_data;
   } host_rsp_t;

   typedef struct packed {
      logic       sleep;
      logic       pll_on;
      logic       oversample_on;
      logic [5:0] dac_on;
   } power_out_t;

   typedef struct packed {
      logic sd_en;
      logic edhd_en;
      logic edhd_ddr;
      logic mode_reserved;
      logic luma_on_rise;
      logic align_reserved;
      logic bus_swap;
   } mode_out_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_PTR  = 4'h2,
      ST_DATA = 4'h4,
      ST_HALT = 4'h8
   } host_state_t;

endpackage

// >>> src/reg_byte.sv
// One host-writable control register with reset value and write mask.
// Assumes write enable and data come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module reg_byte
   import video_regs_pkg::*;
#(
   parameter int unsigned         WIDTH      = 8,
   parameter logic [WIDTH-1:0]    RESET_VAL  = '0,
   parameter logic [WIDTH-1:0]    WRITE_MASK = '1
) (
   input  wire logic             clock_i,
   input  wire logic             rstn_i,
   input  wire logic             wr_en_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   output logic      [WIDTH-1:0] value_o
);

   logic [WIDTH-1:0] value_ff;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         value_ff <= RESET_VAL;
      end else if (wr_en_i) begin
         value_ff <= wr_data_i & WRITE_MASK;
      end
   end

   assign value_o = value_ff;

endmodule
`default_nettype wire

// >>> src/ddr_lane_sort.sv
// Sorts the two half-cycle words of a double-rate input into luma/chroma.
// Assumes rise and fall words were captured upstream on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ddr_lane_sort
   import video_regs_pkg::*;
#(
   parameter int unsigned LANE_W = 10
) (
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   input  wire logic              enable_i,
   input  wire logic              luma_on_rise_i,
   input  wire logic              valid_i,
   input  wire logic [LANE_W-1:0] rise_word_i,
   input  wire logic [LANE_W-1:0] fall_word_i,
   output logic      [LANE_W-1:0] luma_o,
   output logic      [LANE_W-1:0] chroma_o,
   output logic                   valid_o
);

   logic [LANE_W-1:0] luma_ff;
   logic [LANE_W-1:0] chroma_ff;
   logic              valid_ff;
   wire               take_w = valid_i & enable_i;
   wire [LANE_W-1:0]  nxt_luma = luma_on_rise_i ? rise_word_i : fall_word_i;
   wire [LANE_W-1:0]  nxt_chroma = luma_on_rise_i ? fall_word_i : rise_word_i;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         luma_ff   <= '0;
         chroma_ff <= '0;
         valid_ff  <= 1'b0;
      end else begin
         valid_ff <= take_w;
         if (take_w) begin
            luma_ff   <= nxt_luma;
            chroma_ff <= nxt_chroma;
         end
      end
   end

   assign luma_o   = luma_ff;
   assign chroma_o = chroma_ff;
   assign valid_o  = valid_ff;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   chroma_rise_a: assert property (take_w && !luma_on_rise_i |=>
      chroma_o == $past(rise_word_i) && luma_o == $past(fall_word_i))
      else $error("chroma not taken from rising word");
   luma_rise_a: assert property (take_w && luma_on_rise_i |=>
      luma_o == $past(rise_word_i) && chroma_o == $past(fall_word_i))
      else $error("luma not taken from rising word");

endmodule
`default_nettype wire

// >>> src/power_and_input_mode_regs.sv
// Power and input mode register bank behind the host byte port.
// Assumes a serial engine on the same clock delivers start, stop and bytes.
//
// Behaviour
// - An 8-bit write-only pointer is loaded by the first byte written.
// - The pointer picks the register that takes or gives each data byte.
// - Power bit 0 set means sleep, turning off every converter and PLL.
// - Both registers stay readable and writable while asleep.
// - Power bit 1 set powers the PLL down and stops oversampling.
// - Power bits 2, 3, 4 switch converters three, two and one on.
// - Power bits 5, 6, 7 switch converters six, five and four on.
// - Alignment 00 takes chroma on the rising and luma on the falling.
// - Alignment 11 swaps that; 01 and 10 are reserved, DDR only.
// - Mode bits 6:4 choose SD, ED/HD SDR or DDR, or SD with either.
`timescale 1ns/1ps
`default_nettype none
module power_and_input_mode_regs
   import video_regs_pkg::*;
#(
   parameter int unsigned LANE_W = 10
) (
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   input  wire host_req_t         host_req_i,
   output host_rsp_t              host_rsp_o,
   input  wire logic              ddr_word_valid_i,
   input  wire logic [LANE_W-1:0] ddr_rise_word_i,
   input  wire logic [LANE_W-1:0] ddr_fall_word_i,
   output power_out_t             power_o,
   output mode_out_t              mode_o,
   output logic      [LANE_W-1:0] ddr_luma_o,
   output logic      [LANE_W-1:0] ddr_chroma_o,
   output logic                   ddr_valid_o
);

   host_state_t    state_ff;
   host_state_t    nxt_state;
   logic [7:0]     pointer_ff;
   logic [7:0]     nxt_pointer;
   host_rsp_t      rsp_ff;
   host_rsp_t      nxt_rsp;
   power_out_t     power_ff;
   mode_out_t      mode_ff;
   logic [7:0]     power_q;
   logic [7:0]     mode_q;
   power_control_t pwr;
   mode_select_t   msel;

   // Start and stop override any byte seen in the same cycle
   wire       busy_w    = ~host_req_i.start & ~host_req_i.stop;
   wire       in_ptr_w  = (state_ff == ST_PTR);
   wire       in_data_w = (state_ff == ST_DATA);
   wire       ptr_ok_w  = (pointer_ff <= LAST_ADDR);
   wire       new_ok_w  = (host_req_i.wr_data <= LAST_ADDR);
   wire       ptr_load  = busy_w & in_ptr_w & host_req_i.wr_valid;
   wire       data_wr   = busy_w & in_data_w & host_req_i.wr_valid;
   wire       data_rd   = busy_w & (in_ptr_w | in_data_w)
                          & host_req_i.rd_req & ~host_req_i.wr_valid;
   // Writing is never gated by sleep, so setup can happen while asleep
   wire       wr_power  = data_wr & (pointer_ff == POWER_CONTROL_ADDR);
   wire       wr_mode   = data_wr & (pointer_ff == INPUT_MODE_SELECT_ADDR);
   // Reads past the top keep returning the highest register
   wire [7:0] rd_addr_w = ptr_ok_w ? pointer_ff : LAST_ADDR;
   wire [7:0] rd_data_w = (rd_addr_w == POWER_CONTROL_ADDR) ? power_q
                                                           : mode_q;
   // Stepping stops one past the top, so the pointer never wraps
   wire [7:0] ptr_inc_w = ptr_ok_w ? 8'(pointer_ff + 8'h01) : pointer_ff;

   always_comb begin
      nxt_state   = state_ff;
      nxt_pointer = pointer_ff;
      nxt_rsp     = '0;
      if (host_req_i.start) begin
         nxt_state = ST_PTR;
      end else if (host_req_i.stop) begin
         nxt_state = ST_IDLE;
      end else begin
         case (state_ff)
            ST_PTR: begin
               if (ptr_load) begin
                  nxt_pointer       = host_req_i.wr_data;
                  nxt_rsp.ack_valid = 1'b1;
                  nxt_rsp.ack       = new_ok_w;
                  nxt_state         = new_ok_w ? ST_DATA : ST_HALT;
               end else if (data_rd) begin
                  nxt_rsp.rd_valid = 1'b1;
                  nxt_rsp.rd_data  = rd_data_w;
                  nxt_pointer      = ptr_inc_w;
                  nxt_state        = ST_DATA;
               end
            end
            ST_DATA: begin
               if (data_wr) begin
                  nxt_rsp.ack_valid = 1'b1;
                  nxt_rsp.ack       = ptr_ok_w;
                  nxt_pointer       = ptr_inc_w;
                  nxt_state         = ptr_ok_w ? ST_DATA : ST_HALT;
               end else if (data_rd) begin
                  nxt_rsp.rd_valid = 1'b1;
                  nxt_rsp.rd_data  = rd_data_w;
                  nxt_pointer      = ptr_inc_w;
               end
            end
            ST_IDLE, ST_HALT: begin
               nxt_state = state_ff;
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff   <= ST_IDLE;
         pointer_ff <= 8'h00;
         rsp_ff     <= '0;
      end else begin
         state_ff   <= nxt_state;
         pointer_ff <= nxt_pointer;
         rsp_ff     <= nxt_rsp;
      end
   end

   reg_byte #(
      .WIDTH      (8),
      .RESET_VAL  (POWER_CONTROL_RESET),
      .WRITE_MASK (POWER_WRITE_MASK)
   ) power_reg (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .wr_en_i   (wr_power),
      .wr_data_i (host_req_i.wr_data),
      .value_o   (power_q)
   );

   // Masking reserved bits keeps stray host writes out of the decode
   reg_byte #(
      .WIDTH      (8),
      .RESET_VAL  (INPUT_MODE_SELECT_RESET),
      .WRITE_MASK (MODE_WRITE_MASK)
   ) mode_reg (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .wr_en_i   (wr_mode),
      .wr_data_i (host_req_i.wr_data),
      .value_o   (mode_q)
   );

   assign pwr  = power_control_t'(power_q);
   assign msel = mode_select_t'(mode_q);

   wire       awake_w   = ~pwr.sleep;
   wire [5:0] dac_req_w = {pwr.dac6_on, pwr.dac5_on, pwr.dac4_on,
                           pwr.dac3_on, pwr.dac2_on, pwr.dac1_on};
   power_out_t nxt_power;
   assign nxt_power.sleep         = pwr.sleep;
   assign nxt_power.pll_on        = awake_w & ~pwr.pll_off;
   assign nxt_power.oversample_on = awake_w & ~pwr.pll_off;
   assign nxt_power.dac_on        = dac_req_w & {6{awake_w}};

   wire [2:0] im_w = msel.input_mode;
   mode_out_t nxt_mode;
   assign nxt_mode.sd_en = (im_w == MODE_SD_ONLY) | (im_w == MODE_SD_HD_SDR)
                           | (im_w == MODE_SD_HD_DDR);
   assign nxt_mode.edhd_en = (im_w == MODE_HD_SDR) | (im_w == MODE_HD_DDR)
                             | (im_w == MODE_SD_HD_SDR)
                             | (im_w == MODE_SD_HD_DDR);
   assign nxt_mode.edhd_ddr = (im_w == MODE_HD_DDR)
                              | (im_w == MODE_SD_HD_DDR);
   assign nxt_mode.mode_reserved = (im_w > MODE_SD_HD_DDR);
   // Reserved alignment codes fall back to chroma on the rising edge
   assign nxt_mode.luma_on_rise = (msel.edge_align == ALIGN_LUMA_RISE);
   assign nxt_mode.align_reserved = (msel.edge_align != ALIGN_LUMA_RISE)
                                  & (msel.edge_align != ALIGN_CHROMA_RISE);
   assign nxt_mode.bus_swap = msel.bus_swap;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_ff <= '0;
         mode_ff  <= '0;
      end else begin
         power_ff <= nxt_power;
         mode_ff  <= nxt_mode;
      end
   end

   // Alignment only matters for the double-rate ED/HD modes
   ddr_lane_sort #(
      .LANE_W (LANE_W)
   ) lane_sort (
      .clock_i        (clock_i),
      .rstn_i         (rstn_i),
      .enable_i       (mode_ff.edhd_ddr),
      .luma_on_rise_i (mode_ff.luma_on_rise),
      .valid_i        (ddr_word_valid_i),
      .rise_word_i    (ddr_rise_word_i),
      .fall_word_i    (ddr_fall_word_i),
      .luma_o         (ddr_luma_o),
      .chroma_o       (ddr_chroma_o),
      .valid_o        (ddr_valid_o)
   );

   assign host_rsp_o = rsp_ff;
   assign power_o    = power_ff;
   assign mode_o     = mode_ff;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   sequence ptr_write_s;
      ptr_load;
   endsequence
   sequence power_write_s;
      wr_power;
   endsequence

   ptr_load_a: assert property (ptr_write_s |=>
      pointer_ff == $past(host_req_i.wr_data)
      && host_rsp_o.ack_valid)
      else $error("pointer not loaded from first byte");
   reg_target_a: assert property (power_write_s |=>
      power_q == $past(host_req_i.wr_data) ##1
      power_o.dac_on[0] == (power_q[4] & ~power_q[0]))
      else $error("power write did not reach power outputs");
   sleep_gate_a: assert property (pwr.sleep |=>
      power_o.dac_on == 6'h00 && !power_o.pll_on)
      else $error("converters or PLL on during sleep");
   sleep_access_a: assert property (pwr.sleep && wr_mode |=>
      mode_q == ($past(host_req_i.wr_data) & MODE_WRITE_MASK))
      else $error("mode write lost during sleep");
   pll_bit_a: assert property (!pwr.sleep |=>
      power_o.pll_on == !$past(pwr.pll_off)
      && power_o.oversample_on == power_o.pll_on)
      else $error("PLL or oversampling wrong for bit 1");
   dac_low_a: assert property (!pwr.sleep |=>
      power_o.dac_on[0] == $past(power_q[4])
      && power_o.dac_on[1] == $past(power_q[3])
      && power_o.dac_on[2] == $past(power_q[2]))
      else $error("converters one to three wrong");
   dac_high_a: assert property (!pwr.sleep |=>
      power_o.dac_on[3] == $past(power_q[7])
      && power_o.dac_on[4] == $past(power_q[6])
      && power_o.dac_on[5] == $past(power_q[5]))
      else $error("converters four to six wrong");
   align_map_a: assert property (msel.edge_align == ALIGN_LUMA_RISE |=>
      mode_o.luma_on_rise && !mode_o.align_reserved)
      else $error("alignment 11 not decoded");
   mode_ddr_a: assert property (im_w == MODE_SD_HD_DDR |=>
      mode_o.sd_en && mode_o.edhd_en && mode_o.edhd_ddr)
      else $error("SD plus double-rate mode not decoded");
   mode_sdr_a: assert property (im_w == MODE_HD_SDR |=>
      !mode_o.sd_en && mode_o.edhd_en && !mode_o.edhd_ddr)
      else $error("single-rate only mode not decoded");

   sequence mode_write_s;
      wr_mode;
   endsequence
   sequence read_take_s;
      data_rd;
   endsequence

   // Answers must never mix an ack with read data
   rd_answer_a: assert property (read_take_s |=>
      host_rsp_o.rd_valid && !host_rsp_o.ack_valid)
      else $error("read request not answered with data");
   rd_power_a: assert property (data_rd
      && pointer_ff == POWER_CONTROL_ADDR
      |=> host_rsp_o.rd_data == $past(power_q))
      else $error("power register not read back");
   rd_mode_a: assert property (data_rd
      && pointer_ff != POWER_CONTROL_ADDR
      |=> host_rsp_o.rd_data == $past(mode_q))
      else $error("mode register not read back");
   ptr_step_a: assert property ((data_wr || data_rd)
      && pointer_ff == POWER_CONTROL_ADDR
      |=> pointer_ff == INPUT_MODE_SELECT_ADDR)
      else $error("pointer did not step after a byte");
   // Overrun must nack and halt, or a stray byte could land somewhere
   over_nack_a: assert property (data_wr && !ptr_ok_w |=>
      host_rsp_o.ack_valid && !host_rsp_o.ack && state_ff == ST_HALT)
      else $error("write past the top not refused");
   bad_ptr_a: assert property (ptr_load && !new_ok_w |=>
      host_rsp_o.ack_valid && !host_rsp_o.ack && state_ff == ST_HALT)
      else $error("invalid pointer not refused");
   idle_quiet_a: assert property ((state_ff == ST_IDLE
      || state_ff == ST_HALT)
      |=> !host_rsp_o.ack_valid && !host_rsp_o.rd_valid)
      else $error("answer given outside a transaction");
   start_wins_a: assert property (host_req_i.start |=>
      state_ff == ST_PTR && !host_rsp_o.ack_valid && !host_rsp_o.rd_valid)
      else $error("start did not reopen the pointer phase");
   stop_idle_a: assert property (host_req_i.stop
      && !host_req_i.start |=> state_ff == ST_IDLE)
      else $error("stop did not end the transaction");
   mode_path_a: assert property (mode_write_s |=>
      mode_q == ($past(host_req_i.wr_data) & MODE_WRITE_MASK) ##1
      mode_o.edhd_ddr == (mode_q[6:4] == MODE_HD_DDR
                          || mode_q[6:4] == MODE_SD_HD_DDR))
      else $error("mode write did not reach mode outputs");
   sleep_osc_a: assert property (pwr.sleep |=>
      power_o.sleep && !power_o.oversample_on)
      else $error("sleep flag or oversampling wrong");
   mode_resv_a: assert property (im_w > MODE_SD_HD_DDR |=>
      mode_o.mode_reserved && !mode_o.sd_en && !mode_o.edhd_en
      && !mode_o.edhd_ddr)
      else $error("reserved input mode not flagged");
   align_zero_a: assert property (msel.edge_align
      == ALIGN_CHROMA_RISE |=> !mode_o.luma_on_rise
      && !mode_o.align_reserved)
      else $error("alignment 00 not decoded");

endmodule
`default_nettype wire

// >>> tb/host_model.sv
// Host partner: sends byte events to the register bank's host port.
// Assumes the same clock as the bank; answers are gathered per transfer.
`timescale 1ns/1ps
`default_nettype none
module host_model
   import video_regs_pkg::*;
(
   input  wire logic      clock_i,
   input  wire host_rsp_t host_rsp_i,
   output host_req_t      host_req_o
);
   logic [7:0] acks [$];
   logic [7:0] rdat [$];

   initial host_req_o = '0;

   // Answers stand one cycle, so they are caught at every edge
   always @(posedge clock_i) begin
      if (host_rsp_i.ack_valid) acks.push_back({7'h00, host_rsp_i.ack});
      if (host_rsp_i.rd_valid) rdat.push_back(host_rsp_i.rd_data);
   end

   // Start, pointer byte first, data back to back, then stop
   task automatic xfer(input logic [7:0] wr [$], input int nrd);
      host_req_t r;
      acks.delete();
      rdat.delete();
      @(posedge clock_i);
      r = '0;
      r.start = 1'b1;
      host_req_o <= r;
      foreach (wr[i]) begin
         @(posedge clock_i);
         r = '0;
         r.wr_valid = 1'b1;
         r.wr_data = wr[i];
         host_req_o <= r;
      end
      repeat (nrd) begin
         @(posedge clock_i);
         r = '0;
         r.rd_req = 1'b1;
         r.wr_data = ~host_req_o.wr_data;
         host_req_o <= r;
      end
      @(posedge clock_i);
      r = '0;
      r.stop = 1'b1;
      host_req_o <= r;
      @(posedge clock_i);
      // Idle data is all ones, the inverse of the zero stop byte, never the last byte
      r = '0;
      r.wr_data = ~host_req_o.wr_data;
      host_req_o <= r;
      repeat (3) @(posedge clock_i);
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_power_and_input_mode_regs.sv
// Testbench for the power and input mode register bank.
// Assumes the host model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_power_and_input_mode_regs
   import video_regs_pkg::*;
;
   logic       clock_i;
   logic       rstn_i;
   host_req_t  host_req;
   host_rsp_t  host_rsp;
   logic       ddr_v;
   logic [9:0] rise_w;
   logic [9:0] fall_w;
   power_out_t power;
   mode_out_t  mode;
   logic [9:0] luma;
   logic [9:0] chroma;
   logic       ddr_vo;
   int         fails;
   int         checks;
   int         cycles;
   int         dmap [8] = '{0, 0, 2, 1, 0, 5, 4, 3};
   logic [3:0] exp_mode [8] = '{4'h8, 4'h4, 4'h6, 4'hC, 4'hE, 4'h1, 4'h1, 4'h1};

   power_and_input_mode_regs i_power_and_input_mode_regs (
      .clock_i(clock_i), .rstn_i(rstn_i), .host_req_i(host_req),
      .host_rsp_o(host_rsp), .ddr_word_valid_i(ddr_v),
      .ddr_rise_word_i(rise_w), .ddr_fall_word_i(fall_w), .power_o(power),
      .mode_o(mode), .ddr_luma_o(luma), .ddr_chroma_o(chroma),
      .ddr_valid_o(ddr_vo));

   host_model i_host_model (
      .clock_i(clock_i), .host_rsp_i(host_rsp), .host_req_o(host_req));

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   task automatic check(input string name, input logic [9:0] seen,
                        input logic [9:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      i_host_model.xfer('{a, v}, 0);
   endtask

   // Words differ per edge so a swapped lane cannot pass
   task automatic ddr_word(input logic v_exp, input logic [9:0] l_exp,
                           input logic [9:0] c_exp);
      @(posedge clock_i);
      ddr_v <= 1'b1;
      rise_w <= 10'h2A5;
      fall_w <= 10'h15A;
      @(posedge clock_i);
      ddr_v <= 1'b0;
      rise_w <= 10'h15A;
      fall_w <= 10'h2A5;
      #1;
      check("ddr valid", 10'(ddr_vo), 10'(v_exp));
      if (v_exp) begin
         check("luma", luma, l_exp);
         check("chroma", chroma, c_exp);
      end
   endtask

   // Hang guard, far above the roughly 410 cycles of traffic
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         give_verdict();
      end
   end

   initial begin
      rstn_i = 1'b0;
      ddr_v = 1'b0;
      rise_w = 10'h000;
      fall_w = 10'h000;
      fails = 0;
      checks = 0;
      cycles = 0;
      repeat (16) @(posedge clock_i);
      rstn_i <= 1'b1;
      i_host_model.xfer('{8'h00}, 2);
      check("rst power", 10'(i_host_model.rdat[0]), 10'h012);
      check("rst mode", 10'(i_host_model.rdat[1]), 10'h000);
      check("rst power out", 10'(power), 10'h001);
      for (int i = 2; i < 8; i++) begin
         wr_reg(8'h00, 8'(1 << i));
         check("dac", 10'(power), 10'(9'h0C0 | (9'h001 << dmap[i])));
      end
      wr_reg(8'h00, 8'hFD);
      check("sleep out", 10'(power), 10'h100);
      wr_reg(8'h01, 8'h30);
      i_host_model.xfer('{8'h00}, 2);
      check("sleep rd power", 10'(i_host_model.rdat[0]), 10'h0FD);
      check("sleep rd mode", 10'(i_host_model.rdat[1]), 10'h030);
      for (int m = 0; m < 8; m++) begin
         for (int a = 0; a < 4; a++) begin
            wr_reg(8'h01, 8'((m << 4) | (a << 1)));
            check("mode", 10'({mode.sd_en, mode.edhd_en, mode.edhd_ddr,
                  mode.mode_reserved}), 10'(exp_mode[m]));
            check("align", 10'({mode.luma_on_rise, mode.align_reserved}),
                  10'({a == 3, a == 1 || a == 2}));
         end
      end
      ddr_word(1'b0, 10'h000, 10'h000);
      wr_reg(8'h01, 8'hA6);
      check("bus swap", 10'(mode.bus_swap), 10'h001);
      ddr_word(1'b1, 10'h2A5, 10'h15A);
      wr_reg(8'h01, 8'h20);
      ddr_word(1'b1, 10'h15A, 10'h2A5);
      // Third data byte runs past the last register and is refused
      i_host_model.xfer('{8'h00, 8'h5A, 8'h93, 8'h77}, 0);
      for (int k = 0; k < 4; k++) begin
         check("burst ack", 10'(i_host_model.acks[k]), 10'(k < 3));
      end
      i_host_model.xfer('{8'h00}, 3);
      check("burst rd0", 10'(i_host_model.rdat[0]), 10'h05A);
      check("burst rd1", 10'(i_host_model.rdat[1]), 10'h092);
      check("burst rd2", 10'(i_host_model.rdat[2]), 10'h092);
      i_host_model.xfer('{8'h05, 8'h11}, 0);
      check("bad ptr acks", 10'(i_host_model.acks.size()), 10'h001);
      check("bad ptr nack", 10'(i_host_model.acks[0]), 10'h000);
      i_host_model.xfer('{8'h00}, 1);
      check("bad ptr keep", 10'(i_host_model.rdat[0]), 10'h05A);
      give_verdict();
   end
endmodule
`default_nettype wire
